/* File: capture_partner.sv */
// capture_partner: source memory, shared RAM image and host byte sink.
// assumes the capture engine's port timing on one clock.
`timescale 1ns/10ps
`default_nettype none
module capture_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // source memory
  input wire logic memRead,
  input wire logic [15:0] memAddr,
  input wire logic memSelY,
  output logic [23:0] memData,
  // shared memory writes
  input wire logic dpWrite,
  input wire logic [13:0] dpAddr,
  input wire logic [31:0] dpData,
  // host byte sink
  output logic txReady
);
  logic [31:0] sharedWords [0:63];
  logic holdValid_reg;
  logic [23:0] holdData_reg;
  logic [23:0] junk_reg;
  logic [2:0] stall_reg;
  logic [13:0] dpOff;

  function automatic logic [23:0] wordAt(input logic [15:0] a, input logic y);
    return {(y ? 8'h9a : 8'h45), 8'h3c, a[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // data held one cycle past the read, then scrambled so stale values fail
  assign memData = memRead ? wordAt(memAddr, memSelY) :
                   (holdValid_reg ? holdData_reg : junk_reg);
  assign dpOff = dpAddr - 14'h0800;
  // host stalls a quarter of the time
  assign txReady = (stall_reg[1:0] != 2'h0);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdValid_reg <= 1'b0;
      holdData_reg <= 24'h000000;
      junk_reg <= 24'h5aa55a;
      stall_reg <= 3'h0;
    end else begin
      holdValid_reg <= memRead;
      holdData_reg <= wordAt(memAddr, memSelY);
      junk_reg <= ~junk_reg;
      stall_reg <= stall_reg + 3'h1;
      // host view of the buffer, word offset from its start
      if (dpWrite && dpAddr >= 14'h0800 && dpAddr < 14'h0900) begin
        sharedWords[dpOff[7:2]] <= dpData;
      end
    end
  end
endmodule
`default_nettype wire

/* File: capture_pkg.sv */
// capture_pkg: constants and types for the sample capture engine.
// assumes a single 250 MHz clock domain; shared by design and tests.
package capture_pkg;
  localparam int NUM_SOURCES = 24;
  localparam int SRC_W = 18;
  localparam int KIND_LSB = 16;
  localparam logic [1:0] KIND_X = 2'h0;
  localparam logic [1:0] KIND_Y = 2'h1;
  localparam logic [1:0] KIND_FIX = 2'h2;
  localparam logic [1:0] KIND_FLT = 2'h3;
  localparam logic [1:0] DEST_INTERNAL = 2'h0;
  localparam logic [1:0] DEST_DPRAM = 2'h3;
  // shared-memory layout: byte offsets from the shared memory base, base word address and sizes in words
  localparam logic [15:0] BUF_BASE_WORD = 16'hd200;
  localparam logic [13:0] BUF_BASE_BYTE = 14'h0800;
  localparam logic [13:0] NEXT_PTR_BYTE = 14'h07fc;
  localparam logic [13:0] END_PTR_BYTE = 14'h07fe;
  localparam logic [15:0] DP_MAX_WORDS = 16'h0dac;
  localparam logic [15:0] INT_WORDS = 16'h0200;
  localparam int INT_AW = 9;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] MIN_PERIOD = 16'h0001;
  // upload and snapshot unit counts per 24-bit word
  localparam logic [3:0] HEX_UNITS = 4'h6;
  localparam logic [3:0] BIN_UNITS = 4'h3;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_ALPHA = 8'h37;
  localparam int SIGN_BIT = 23;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SCAN = 6'h02,
    ST_FETCH = 6'h04,
    ST_LOAD = 6'h08,
    ST_EMIT = 6'h10,
    ST_DONE = 6'h20
  } walk_state_type;

  typedef enum logic [2:0] {
    MODE_CAP = 3'h1,
    MODE_SNAP = 3'h2,
    MODE_UPL = 3'h4
  } walk_mode_type;
endpackage

/* File: dpram_sample_capture.sv */
// dpram_sample_capture: periodic sampling of up to 24 sources into a
// circular shared-memory buffer or an internal buffer, with hex upload
// and binary snapshot on one byte stream.
// assumes source memory answers a read in the same cycle that memRead is high.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RULE1) capture up to 24 sources per sample, paced by servo ticks
// (RULE2) low 16 address bits give word, top two bits select X, Y or long
// (RULE3) mask chooses which configured sources are collected
// (RULE4) sample interval is a count of servo interrupt cycles
// (RULE5) keep sampling after start until halt or reserved space exhausted
// (RULE6) reserve with zero size takes all remaining memory
// (RULE7) upload sends hex text, six chars per short, twelve per long
// (RULE8) text grouped by twelve; odd half group padded with servo counter
// (RULE9) snapshot sends binary, three bytes per short, six per long
// (RULE10) destination 3 selects shared RAM, 0 selects internal memory
// (RULE11) shared buffer starts at word d200, byte offset 0800, 32-bit words
// (RULE12) short source takes one buffer word, long source two consecutive
// (RULE13) host keeps buffer size at or below 3500 words
// (RULE14) buffer-end pointer at 07fe holds the reserved size; code drives it on bufferEndOffset only, never writes 07fe
// (RULE15) storage pointer at 07fc marks next write; host polls it; code drives it on nextWriteOffset only, never writes 07fc
// (RULE16) both pointers are word offsets from buffer start
// (RULE17) storage pointer wraps to zero when reaching the end pointer
// (RULE18) no item starts at end word; long second half may land there
// (RULE19) each 24-bit value stored sign-extended to 32 bits, low byte first
// (RULE20) long item stored as two separately sign-extended halves
// (RULE21) float long: lower word has exponent and low mantissa bits
// (RULE22) host removes exponent offset 2047 and mantissa scaling 35
// (RULE23) control bit set and clear act as start and halt
// (RULE24) count servo ticks, sample at programmed period, then reload
module dpram_sample_capture (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // configuration settings
  input wire logic [15:0] samplePeriodSetting,
  input wire logic [23:0] sourceSelectMask,
  input wire logic [23:0][17:0] sourceAddrs,
  input wire logic [1:0] captureDestinationSelect,
  // commands, one-cycle pulses, except captureControlBit, which is a level, and reserveSize, a held value
  input wire logic bufferReserveCommand,
  input wire logic [15:0] reserveSize,
  input wire logic bufferReleaseCommand,
  input wire logic captureStartCommand,
  input wire logic captureHaltCommand,
  input wire logic uploadCommand,
  input wire logic snapshotCommand,
  input wire logic captureControlBit,
  input wire logic servoTick,
  // source memory read port
  output logic memRead,
  output logic [15:0] memAddr,
  output logic memSelY,
  input wire logic [23:0] memData,
  // shared memory write port
  output logic dpWrite,
  output logic [13:0] dpAddr,
  output logic [31:0] dpData,
  output logic [15:0] nextWriteOffset,
  output logic [15:0] bufferEndOffset,
  // byte stream to host
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  // status
  output logic capturing
);

  typedef struct packed {
    capture_pkg::walk_state_type st;
    capture_pkg::walk_mode_type mode;
    logic running;
    logic ctrlPrev;
    logic pending;
    logic snapPend;
    logic uplPend;
    logic padding;
    logic oddUnit;
    logic half;
    logic [4:0] srcIdx;
    logic [3:0] units;
    logic [15:0] endOff;
    logic [15:0] wrPtr;
    logic [15:0] fill;
    logic [15:0] work;
    logic [15:0] rdPtr;
    logic [15:0] periodCnt;
    logic [23:0] servoCount;
    logic [23:0] word;
    logic memRead;
    logic [15:0] memAddr;
    logic memSelY;
    logic dpWrite;
    logic [13:0] dpAddr;
    logic [31:0] dpData;
    logic txValid;
    logic [7:0] txData;
    logic intWrite;
    logic [8:0] intAddr;
    logic [23:0] intData;
  } cap_state_type;

  localparam cap_state_type RESET_STATE = '{
    st: capture_pkg::ST_IDLE, mode: capture_pkg::MODE_CAP, default: '0};

  cap_state_type s_reg;
  cap_state_type s_next;
  logic [23:0] bufMem [capture_pkg::INT_WORDS];
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    if (n < 4'ha) begin
      return capture_pkg::ASCII_ZERO + {4'h0, n};
    end
    return capture_pkg::ASCII_ALPHA + {4'h0, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [17:0] curSrc;
  logic [1:0] curKind;
  logic curLong;
  logic [15:0] periodEff;
  logic [15:0] intLimit;
  logic startReq;
  logic haltReq;

  assign curSrc = sourceAddrs[s_reg.srcIdx];
  assign curKind = curSrc[capture_pkg::KIND_LSB +: 2];
  assign curLong = curKind[1];
  assign periodEff = (samplePeriodSetting == 16'h0000) ? capture_pkg::MIN_PERIOD
                                                       : samplePeriodSetting;
  assign intLimit = (s_reg.endOff > capture_pkg::INT_WORDS) ? capture_pkg::INT_WORDS
                                                            : s_reg.endOff;
  assign startReq = captureStartCommand | (captureControlBit & ~s_reg.ctrlPrev); // [RULE23]
  assign haltReq = captureHaltCommand | (~captureControlBit & s_reg.ctrlPrev); // [RULE23]

  always_comb begin
    logic startEmit;
    logic [23:0] emitWord;
    logic advance;
    logic [15:0] ptrUse;
    logic [15:0] ptrInc;
    startEmit = 1'b0;
    emitWord = s_reg.word;
    advance = 1'b0;
    ptrUse = s_reg.wrPtr;
    ptrInc = 16'h0000;
    s_next = s_reg;
    s_next.memRead = 1'b0;
    s_next.dpWrite = 1'b0;
    s_next.intWrite = 1'b0;
    s_next.ctrlPrev = captureControlBit;
    if (snapshotCommand) begin
      s_next.snapPend = 1'b1;
    end
    if (uploadCommand) begin
      s_next.uplPend = 1'b1;
    end
    if (servoTick) begin
      s_next.servoCount = s_reg.servoCount + 24'h000001;
    end
    // sample pacing: reload after each period
    if (s_reg.running && servoTick) begin
      if (s_reg.periodCnt + 16'h0001 >= periodEff) begin // [RULE4]
        s_next.periodCnt = capture_pkg::PTR_RESET; // [RULE24]
        s_next.pending = 1'b1; // [RULE24]
      end else begin
        s_next.periodCnt = s_reg.periodCnt + 16'h0001;
      end
    end
    if (bufferReserveCommand) begin
      if (reserveSize == 16'h0000) begin // [RULE6]
        s_next.endOff = (captureDestinationSelect == capture_pkg::DEST_DPRAM)
                        ? capture_pkg::DP_MAX_WORDS : capture_pkg::INT_WORDS;
      end else begin
        s_next.endOff = reserveSize; // [RULE14]
      end
    end
    if (startReq && s_reg.endOff != 16'h0000) begin
      s_next.running = 1'b1; // [RULE5]
      s_next.periodCnt = capture_pkg::PTR_RESET;
      s_next.wrPtr = capture_pkg::PTR_RESET;
      s_next.fill = capture_pkg::PTR_RESET;
      s_next.work = capture_pkg::PTR_RESET;
    end
    if (haltReq || bufferReleaseCommand) begin
      s_next.running = 1'b0; // [RULE5]
      s_next.pending = 1'b0;
    end
    if (bufferReleaseCommand) begin
      s_next.endOff = capture_pkg::PTR_RESET;
      s_next.fill = capture_pkg::PTR_RESET;
    end
    unique case (s_reg.st)
      capture_pkg::ST_IDLE: begin
        s_next.srcIdx = 5'h00;
        s_next.half = 1'b0;
        s_next.oddUnit = 1'b0;
        // snapshot first: it is the only latency-sensitive request
        if (s_reg.snapPend) begin
          // a request arriving in this very cycle is kept, not lost
          s_next.snapPend = snapshotCommand;
          s_next.mode = capture_pkg::MODE_SNAP;
          s_next.st = capture_pkg::ST_SCAN;
        end else if (s_reg.pending && s_reg.running) begin
          s_next.pending = s_reg.running && servoTick && !haltReq && !bufferReleaseCommand
                           && (s_reg.periodCnt + 16'h0001 >= periodEff); // [RULE24]
          s_next.mode = capture_pkg::MODE_CAP;
          s_next.work = s_reg.fill;
          s_next.st = capture_pkg::ST_SCAN;
        end else if (s_reg.uplPend && !s_reg.running) begin
          s_next.uplPend = uploadCommand;
          s_next.mode = capture_pkg::MODE_UPL;
          s_next.rdPtr = capture_pkg::PTR_RESET;
          s_next.st = (s_reg.fill != 16'h0000 && sourceSelectMask != 24'h000000)
                      ? capture_pkg::ST_SCAN : capture_pkg::ST_IDLE;
        end
      end
      capture_pkg::ST_SCAN: begin
        if (s_reg.srcIdx == 5'(capture_pkg::NUM_SOURCES)) begin // [RULE1]
          if (s_reg.mode == capture_pkg::MODE_UPL && s_reg.oddUnit) begin
            s_next.padding = 1'b1; // [RULE8]
            s_next.oddUnit = 1'b0;
            emitWord = s_reg.servoCount; // [RULE8]
            startEmit = 1'b1;
          end else begin
            s_next.st = capture_pkg::ST_DONE;
          end
        end else if (sourceSelectMask[s_reg.srcIdx]) begin // [RULE3]
          s_next.st = capture_pkg::ST_FETCH;
        end else begin
          s_next.srcIdx = s_reg.srcIdx + 5'h01;
        end
      end
      capture_pkg::ST_FETCH: begin
        if (s_reg.mode == capture_pkg::MODE_UPL) begin
          emitWord = bufMem[s_reg.rdPtr[capture_pkg::INT_AW-1:0]];
          startEmit = 1'b1;
        end else begin
          // long items read their lower word (Y) first
          s_next.memRead = 1'b1;
          s_next.memAddr = curSrc[15:0]; // [RULE2]
          s_next.memSelY = (curKind == capture_pkg::KIND_Y) || (curLong && !s_reg.half);
          s_next.st = capture_pkg::ST_LOAD;
        end
      end
      capture_pkg::ST_LOAD: begin
        if (s_reg.mode == capture_pkg::MODE_SNAP) begin
          emitWord = memData;
          startEmit = 1'b1;
        end else if (captureDestinationSelect == capture_pkg::DEST_DPRAM) begin // [RULE10]
          if (!s_reg.half && s_reg.wrPtr >= s_reg.endOff) begin
            ptrUse = capture_pkg::PTR_RESET; // [RULE18]
          end
          ptrInc = ptrUse + 16'h0001;
          s_next.dpWrite = 1'b1;
          s_next.dpAddr = capture_pkg::BUF_BASE_BYTE + {ptrUse[11:0], 2'b00}; // [RULE11]
          s_next.dpData = {{8{memData[capture_pkg::SIGN_BIT]}}, memData}; // [RULE19] [RULE20]
          if (curLong && !s_reg.half) begin
            s_next.wrPtr = ptrInc; // [RULE18] [RULE21]
          end else begin
            s_next.wrPtr = (ptrInc >= s_reg.endOff) ? capture_pkg::PTR_RESET : ptrInc; // [RULE17]
          end
          advance = 1'b1;
        end else if (captureDestinationSelect == capture_pkg::DEST_INTERNAL) begin
          if (s_reg.work >= intLimit) begin
            s_next.running = 1'b0; // [RULE5]
            s_next.pending = 1'b0;
            s_next.st = capture_pkg::ST_IDLE;
          end else begin
            s_next.intWrite = 1'b1; // [RULE12]
            s_next.intAddr = s_reg.work[capture_pkg::INT_AW-1:0];
            s_next.intData = memData;
            s_next.work = s_reg.work + 16'h0001;
            advance = 1'b1;
          end
        end else begin
          advance = 1'b1;
        end
      end
      capture_pkg::ST_EMIT: begin
        if (s_reg.txValid && txReady) begin
          if (s_reg.units == 4'h1) begin
            s_next.txValid = 1'b0;
            if (s_reg.padding) begin
              s_next.padding = 1'b0;
              s_next.st = capture_pkg::ST_DONE;
            end else begin
              advance = 1'b1;
            end
          end else begin
            s_next.units = s_reg.units - 4'h1;
            if (s_reg.mode == capture_pkg::MODE_UPL) begin
              s_next.word = {s_reg.word[19:0], 4'h0};
              s_next.txData = hexChar(s_reg.word[19:16]); // [RULE7]
            end else begin
              s_next.word = {s_reg.word[15:0], 8'h00};
              s_next.txData = s_reg.word[15:8]; // [RULE9]
            end
          end
        end
      end
      capture_pkg::ST_DONE: begin
        s_next.srcIdx = 5'h00;
        s_next.half = 1'b0;
        if (s_reg.mode == capture_pkg::MODE_CAP) begin
          s_next.fill = s_reg.work;
          s_next.st = capture_pkg::ST_IDLE;
        end else if (s_reg.mode == capture_pkg::MODE_UPL && s_reg.rdPtr < s_reg.fill) begin
          s_next.st = capture_pkg::ST_SCAN;
        end else begin
          s_next.st = capture_pkg::ST_IDLE;
        end
      end
    endcase
    if (startEmit) begin
      s_next.word = emitWord;
      s_next.txValid = 1'b1;
      s_next.st = capture_pkg::ST_EMIT;
      if (s_reg.mode == capture_pkg::MODE_UPL) begin
        s_next.units = capture_pkg::HEX_UNITS; // [RULE7]
        s_next.txData = hexChar(emitWord[23:20]);
      end else begin
        s_next.units = capture_pkg::BIN_UNITS; // [RULE9]
        s_next.txData = emitWord[23:16];
      end
    end
    if (advance) begin
      if (s_reg.mode == capture_pkg::MODE_UPL) begin
        s_next.rdPtr = s_reg.rdPtr + 16'h0001;
        s_next.oddUnit = ~s_reg.oddUnit; // [RULE8]
      end
      if (curLong && !s_reg.half) begin
        s_next.half = 1'b1; // [RULE12]
      end else begin
        s_next.half = 1'b0;
        s_next.srcIdx = s_reg.srcIdx + 5'h01;
      end
      s_next.st = capture_pkg::ST_SCAN;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // no reset: contents are meaningless until written by a capture
  always_ff @(posedge ref_clk) begin
    if (s_reg.intWrite) begin
      bufMem[s_reg.intAddr] <= s_reg.intData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign memRead = s_reg.memRead;
  assign memAddr = s_reg.memAddr;
  assign memSelY = s_reg.memSelY;
  assign dpWrite = s_reg.dpWrite;
  assign dpAddr = s_reg.dpAddr;
  assign dpData = s_reg.dpData;
  assign nextWriteOffset = s_reg.wrPtr; // [RULE15] [RULE16]
  assign bufferEndOffset = s_reg.endOff; // [RULE14] [RULE16]
  assign txValid = s_reg.txValid;
  assign txData = s_reg.txData;
  assign capturing = s_reg.running;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_SOURCE_LIMIT: assert property (s_reg.srcIdx <= 5'd24) // [RULE1]
    else $error("source index past last source");
  AST_ADDR_LOW: assert property (s_reg.st == capture_pkg::ST_FETCH // [RULE2]
      && s_reg.mode != capture_pkg::MODE_UPL |=> memRead && memAddr == $past(curSrc[15:0]))
    else $error("source address not taken from low bits");
  AST_MASK_SEL: assert property (memRead |-> sourceSelectMask[s_reg.srcIdx]) // [RULE3]
    else $error("unmasked source read");
  AST_PERIOD: assert property (s_reg.running |-> s_reg.periodCnt < periodEff) // [RULE4]
    else $error("period counter exceeded interval");
  AST_HALT: assert property (captureHaltCommand && !captureStartCommand // [RULE5]
      && !captureControlBit |=> !capturing)
    else $error("halt did not stop capture");
  AST_DP_BASE: assert property (dpWrite |-> dpAddr >= capture_pkg::BUF_BASE_BYTE // [RULE11]
      && dpAddr[1:0] == 2'b00)
    else $error("shared write outside buffer");
  AST_SIGN_EXT: assert property (dpWrite |-> dpData[31:24] == {8{dpData[23]}}) // [RULE19]
    else $error("top byte not sign extension");
  AST_WRAP: assert property (dpWrite && !s_reg.half |-> nextWriteOffset < bufferEndOffset) // [RULE17]
    else $error("storage pointer not wrapped");
  AST_HEX_TEXT: assert property (txValid && s_reg.mode == capture_pkg::MODE_UPL // [RULE7]
      |-> (txData >= 8'h30 && txData <= 8'h39) || (txData >= 8'h41 && txData <= 8'h46))
    else $error("upload char not hex");
  AST_RESERVE_ALL: assert property (bufferReserveCommand && reserveSize == 16'h0000 // [RULE6]
      && !bufferReleaseCommand |=> bufferEndOffset != 16'h0000)
    else $error("reserve all left empty buffer");

endmodule

`default_nettype wire

/* File: test_dpram_sample_capture.sv */
// test_dpram_sample_capture: directed tests of the capture engine.
// assumes capture_pkg and capture_partner are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_dpram_sample_capture;
  logic ref_clk, arst_n, captureControlBit, servoTick;
  logic [15:0] samplePeriodSetting, reserveSize;
  logic [23:0] sourceSelectMask;
  logic [23:0][17:0] sourceAddrs;
  logic [1:0] captureDestinationSelect;
  logic [5:0] cmd;
  logic memRead, memSelY, dpWrite, txValid, txReady, capturing;
  logic [15:0] memAddr, nextWriteOffset, bufferEndOffset;
  logic [23:0] memData;
  logic [13:0] dpAddr;
  logic [31:0] dpData;
  logic [7:0] txData;
  int n_fail, n_compared, nWrites;
  logic [23:0] nTicks;
  logic [7:0] rx [$];
  logic [23:0] ew [$];

  dpram_sample_capture dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .samplePeriodSetting(samplePeriodSetting), .sourceSelectMask(sourceSelectMask),
    .sourceAddrs(sourceAddrs), .captureDestinationSelect(captureDestinationSelect),
    .bufferReserveCommand(cmd[0]), .reserveSize(reserveSize),
    .bufferReleaseCommand(cmd[1]), .captureStartCommand(cmd[2]),
    .captureHaltCommand(cmd[3]), .uploadCommand(cmd[4]), .snapshotCommand(cmd[5]),
    .captureControlBit(captureControlBit), .servoTick(servoTick),
    .memRead(memRead), .memAddr(memAddr), .memSelY(memSelY), .memData(memData),
    .dpWrite(dpWrite), .dpAddr(dpAddr), .dpData(dpData),
    .nextWriteOffset(nextWriteOffset), .bufferEndOffset(bufferEndOffset),
    .txValid(txValid), .txData(txData), .txReady(txReady), .capturing(capturing));

  capture_partner partner (.ref_clk(ref_clk), .arst_n(arst_n), .memRead(memRead),
    .memAddr(memAddr), .memSelY(memSelY), .memData(memData), .dpWrite(dpWrite),
    .dpAddr(dpAddr), .dpData(dpData), .txReady(txReady));

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (dpWrite === 1'b1) nWrites++;
    if (txValid === 1'b1 && txReady === 1'b1) rx.push_back(txData);
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] wd(input logic [15:0] a, input logic y);
    return {(y ? 8'h9a : 8'h45), 8'h3c, a[7:0]};
  endfunction

  function automatic logic [7:0] hexch(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // expected word order: ascending source, long items lower word Y first
  task automatic build_exp(input logic [23:0] m);
    ew.delete();
    for (int i = 0; i < 24; i++) begin
      if (m[i]) begin
        if (sourceAddrs[i][17:16] == capture_pkg::KIND_X) begin
          ew.push_back(wd(sourceAddrs[i][15:0], 1'b0));
        end else if (sourceAddrs[i][17:16] == capture_pkg::KIND_Y) begin
          ew.push_back(wd(sourceAddrs[i][15:0], 1'b1));
        end else begin
          ew.push_back(wd(sourceAddrs[i][15:0], 1'b1));
          ew.push_back(wd(sourceAddrs[i][15:0], 1'b0));
        end
      end
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(input int b);
    @(posedge ref_clk) cmd <= 6'(32'h1 << b);
    @(posedge ref_clk) cmd <= 6'h00;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk) servoTick <= 1'b1;
      nTicks = nTicks + 24'h000001;
      @(posedge ref_clk) servoTick <= 1'b0;
      repeat (60) @(posedge ref_clk);
    end
  endtask

  // bounded wait, then linger so surplus bytes are seen
  task automatic wait_rx(input int n);
    for (int i = 0; i < 400 && rx.size() < n; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    final_report;
  end

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    cmd = 6'h00;
    servoTick = 1'b0;
    captureControlBit = 1'b0;
    reserveSize = 16'h0005;
    samplePeriodSetting = 16'h0002;
    sourceSelectMask = 24'h000005;
    captureDestinationSelect = capture_pkg::DEST_DPRAM;
    sourceAddrs = '0;
    sourceAddrs[0] = {capture_pkg::KIND_X, 16'h0010};
    sourceAddrs[1] = {capture_pkg::KIND_Y, 16'h0011};
    sourceAddrs[2] = {capture_pkg::KIND_FIX, 16'h0020};
    sourceAddrs[3] = {capture_pkg::KIND_FLT, 16'h0030};
    sourceAddrs[23] = {capture_pkg::KIND_X, 16'h0017};
    nWrites = 0;
    nTicks = 24'h000000;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, capturing, nextWriteOffset}, 32'h0, "reset state");
    chk({16'h0, bufferEndOffset}, 32'h0, "reset end");
    $display("test reset done");

    issue(0);
    chk({16'h0, bufferEndOffset}, 32'h5, "end offset");
    issue(2);
    chk({31'h0, capturing}, 32'h1, "started");
    ticks(1);
    chk(nWrites, 32'h0, "early sample");
    ticks(1);
    chk(nWrites, 32'h3, "one sample");
    chk({16'h0, nextWriteOffset}, 32'h3, "pointer");
    build_exp(24'h000005);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) ticks(2);
      chk(partner.sharedWords[i], {{8{ew[i % 3][23]}}, ew[i % 3]}, "word");
    end
    chk({16'h0, nextWriteOffset}, 32'h0, "wrap");
    issue(3);
    chk({31'h0, capturing}, 32'h0, "halted");
    ticks(2);
    chk(nWrites, 32'h6, "no writes after halt");
    $display("test shared capture done");

    @(posedge ref_clk) captureControlBit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, capturing}, 32'h1, "bit start");
    captureControlBit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, capturing}, 32'h0, "bit stop");
    $display("test control bit done");

    // long items and the last source slot go out as raw bytes
    sourceSelectMask <= 24'h80000f;
    build_exp(24'h80000f);
    rx.delete();
    issue(5);
    wait_rx(21);
    chk(rx.size(), 32'd21, "snapshot size");
    for (int i = 0; i < 21 && i < rx.size(); i++) begin
      chk(rx[i], ew[i / 3][23 - 8 * (i % 3) -: 8], "snap byte");
    end
    // host side: exponent of the float item sits in the low bits of its lower word
    chk({rx[13][3:0], rx[14]} - 12'h7ff, 32'h431, "float exponent");
    $display("test snapshot done");

    issue(1);
    chk({16'h0, bufferEndOffset}, 32'h0, "released");
    issue(2);
    chk({31'h0, capturing}, 32'h0, "start refused");
    reserveSize <= 16'h0000;
    issue(0);
    chk({16'h0, bufferEndOffset}, 32'h0dac, "all shared");
    captureDestinationSelect <= capture_pkg::DEST_INTERNAL;
    issue(0);
    chk({16'h0, bufferEndOffset}, 32'h0200, "all internal");
    $display("test reserve done");

    sourceSelectMask <= 24'h000001;
    samplePeriodSetting <= 16'h0001;
    issue(2);
    ticks(1);
    chk(nWrites, 32'h6, "internal not shared");
    issue(3);
    build_exp(24'h000001);
    rx.delete();
    issue(4);
    wait_rx(12);
    chk(rx.size(), 32'd12, "upload size");
    for (int k = 0; k < 12 && k < rx.size(); k++) begin
      if (k < 6) chk(rx[k], hexch(ew[0][23 - 4 * k -: 4]), "hex char");
      else chk(rx[k], hexch(nTicks[23 - 4 * (k - 6) -: 4]), "pad char");
    end
    $display("test upload done");

    // a destination that is neither shared nor internal walks but stores nothing
    captureDestinationSelect <= 2'h1;
    issue(2);
    ticks(1);
    chk({31'h0, capturing}, 32'h1, "discard running");
    chk(nWrites, 32'h6, "discard not shared");
    $display("test discard done");
    final_report;
  end
endmodule
`default_nettype wire
